// ### logic/psf_pkg.sv
package psf_pkg;
	// ****************************************
	// Clock and time base
	// ****************************************
	localparam int CLK_PERIOD_NS = 10;
	localparam int TICK_TIME_US = 1000;
	localparam int TICK_CYCLES = (TICK_TIME_US * 1000) / CLK_PERIOD_NS;
	localparam int TICK_MS = TICK_TIME_US / 1000;
	// Half phases of the square waves, in ms
	localparam int MINUTE_HALF_MS = 30000;
	localparam int SECOND_HALF_MS = 500;
	localparam int TENTH_HALF_MS = 50;
	localparam int TWENTIETH_HALF_MS = 25;
	localparam int MINUTE_HALF_TICKS = MINUTE_HALF_MS / TICK_MS;
	localparam int SECOND_HALF_TICKS = SECOND_HALF_MS / TICK_MS;
	localparam int TENTH_HALF_TICKS = TENTH_HALF_MS / TICK_MS;
	localparam int TWENTIETH_HALF_TICKS = TWENTIETH_HALF_MS / TICK_MS;
	localparam int WAVE_CNT_W = 15;
	localparam int NUM_WAVES = 4;

	// ****************************************
	// Register map (byte addresses)
	// ****************************************
	localparam int ADDR_W = 8;
	localparam logic [7:0] SYS_CONFIG_OFS = 8'h00;
	localparam logic [7:0] ERROR_CODE_OFS = 8'h04;
	localparam logic [7:0] FLAG_STATUS_OFS = 8'h08;
	localparam logic [7:0] PRESET_EQUAL_OFS = 8'h0C;
	localparam logic [7:0] PRESET_BASE_OFS = 8'h80;
	localparam int NUM_PRESETS = 24;
	localparam logic [15:0] SYS_CONFIG_RST = 16'h0000;
	localparam logic [15:0] ERROR_CODE_RST = 16'h0000;
	localparam int CFG_IO_CHECK_BIT = 0;
	localparam int CFG_BATT_MON_BIT = 12;
endpackage

// ### logic/psf_status_flag_unit.sv
// Design decisions made here: the plain strobed port and the register addresses.
`timescale 1ns/1ns
// Summary of operation
// - First-scan flag on only for first scan
// - Constant true, constant false, per-scan toggle flags
// - Minute wave: 30 s true, 30 s false
// - Second wave: half second each phase
// - Tenth-second wave: 50 ms each phase
// - Twentieth-second wave: 25 ms each phase
// - Run-mode and program-mode flags follow CPU
// - Stop instruction sets forced-stop flag
// - Enable-interrupts instruction sets interrupts-enabled flag
// - Critical flag on severe faults, warning on battery low
// - Battery-low only when monitor bit 12 set
// - Memory error and I/O error flags
// - I/O config error only when check enabled
// - Fault, watchdog, solve-logic flags kept distinct
// - Grammar error flag plus stored error code
// - Compare sets exactly one of less/equal/greater
// - Zero result and load-zero flags
// - Half and full borrow/carry for 16/32-bit
// - Sign, overflow, underflow flags
// - Invalid octal and data error flags
// - Counter module first input mirrored
// - 24 preset equal flags, consecutive preset words
module psf_status_flag_unit #(
	parameter int TICK_CYCLES = psf_pkg::TICK_CYCLES,
	parameter int CNT_W = 16
) (
	// Clock and reset
	input wire logic core_clk_i,
	input wire logic rst_n_i,
	// Register port
	input wire logic [psf_pkg::ADDR_W-1:0] reg_addr_i,
	input wire logic [31:0] reg_wdata_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	output logic [31:0] reg_rdata_o,
	// Scan and mode
	input wire logic scan_start_i,
	input wire logic run_mode_i,
	input wire logic stop_instr_i,
	input wire logic enable_interrupts_instr_i,
	input wire logic disable_interrupts_instr_i,
	// Fault events
	input wire logic io_comm_loss_i,
	input wire logic battery_low_pin_i,
	input wire logic parity_error_i,
	input wire logic io_module_removed_i,
	input wire logic io_bus_error_i,
	input wire logic io_config_mismatch_i,
	input wire logic fault_instr_i,
	input wire logic watchdog_expired_i,
	input wire logic solve_logic_fail_i,
	input wire logic syntax_error_i,
	input wire logic [15:0] syntax_code_i,
	// Accumulator results
	input wire logic instr_done_i,
	input wire logic load_instr_i,
	input wire logic compare_i,
	input wire logic add16_i,
	input wire logic add32_i,
	input wire logic sub16_i,
	input wire logic sub32_i,
	input wire logic carry_out_i,
	input wire logic [31:0] acc_i,
	input wire logic [31:0] prev_acc_i,
	input wire logic [31:0] operand_i,
	input wire logic underflow_i,
	input wire logic invalid_octal_i,
	input wire logic bcd_error_i,
	// Counter interface module
	input wire logic counter_module_input_zero_i,
	input wire logic [CNT_W-1:0] counter_value_i,
	// Flags
	output logic first_scan_flag_o,
	output logic always_true_flag_o,
	output logic always_false_flag_o,
	output logic minute_square_wave_o,
	output logic second_square_wave_o,
	output logic tenth_second_square_wave_o,
	output logic twentieth_second_square_wave_o,
	output logic alternating_scan_flag_o,
	output logic run_mode_flag_o,
	output logic program_mode_flag_o,
	output logic forced_stop_flag_o,
	output logic interrupts_enabled_flag_o,
	output logic critical_error_flag_o,
	output logic warning_flag_o,
	output logic battery_low_flag_o,
	output logic program_memory_error_flag_o,
	output logic io_error_flag_o,
	output logic io_config_error_flag_o,
	output logic fault_instr_flag_o,
	output logic watchdog_timeout_flag_o,
	output logic grammar_error_flag_o,
	output logic solve_logic_error_flag_o,
	output logic less_than_flag_o,
	output logic equal_flag_o,
	output logic greater_than_flag_o,
	output logic zero_result_flag_o,
	output logic half_borrow_flag_o,
	output logic full_borrow_flag_o,
	output logic half_carry_flag_o,
	output logic full_carry_flag_o,
	output logic sign_flag_o,
	output logic invalid_octal_flag_o,
	output logic overflow_flag_o,
	output logic underflow_flag_o,
	output logic data_error_flag_o,
	output logic load_zero_flag_o,
	output logic counter_input_mirror_flag_o,
	output logic [psf_pkg::NUM_PRESETS-1:0] preset_equal_flags_o
);
	generate
		if (CNT_W < 1 || CNT_W > 32 || TICK_CYCLES < 3) begin : g_bad_param
			$error("psf_status_flag_unit: unsupported parameter value");
		end
	endgenerate

	localparam int TICK_W = $clog2(TICK_CYCLES);
	localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(TICK_CYCLES - 1);
	localparam int HALF_TICKS [psf_pkg::NUM_WAVES] = '{psf_pkg::MINUTE_HALF_TICKS,
		psf_pkg::SECOND_HALF_TICKS, psf_pkg::TENTH_HALF_TICKS,
		psf_pkg::TWENTIETH_HALF_TICKS};

	function automatic logic is_reg(input logic [psf_pkg::ADDR_W-1:0] a,
		input logic [psf_pkg::ADDR_W-1:0] ofs);
		is_reg = (a == ofs);
	endfunction

	// ****************************************
	// Synchronisers for pins
	// ****************************************
	logic [1:0] batt_sync_reg;
	logic [1:0] cim_sync_reg;
	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			batt_sync_reg <= 2'h0;
			cim_sync_reg <= 2'h0;
		end else begin
			batt_sync_reg <= {batt_sync_reg[0], battery_low_pin_i};
			cim_sync_reg <= {cim_sync_reg[0], counter_module_input_zero_i};
		end
	end

	// ****************************************
	// Real-time tick and square waves
	// ****************************************
	logic [TICK_W-1:0] tick_cnt_reg;
	logic tick;
	assign tick = (tick_cnt_reg == TICK_LAST);
	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) tick_cnt_reg <= '0;
		else tick_cnt_reg <= tick ? '0 : tick_cnt_reg + 1'b1;
	end

	logic [psf_pkg::NUM_WAVES-1:0] wave_reg;
	genvar gw;
	generate
		for (gw = 0; gw < psf_pkg::NUM_WAVES; gw++) begin : g_wave
			localparam logic [psf_pkg::WAVE_CNT_W-1:0] LAST =
				psf_pkg::WAVE_CNT_W'(HALF_TICKS[gw] - 1);
			logic [psf_pkg::WAVE_CNT_W-1:0] cnt_reg;
			logic flip;
			assign flip = tick && (cnt_reg == LAST);
			// Starts true; each phase is one half period of ticks
			always_ff @(posedge core_clk_i or negedge rst_n_i) begin
				if (!rst_n_i) begin
					cnt_reg <= '0;
					wave_reg[gw] <= 1'b1;
				end else if (tick) begin
					cnt_reg <= flip ? '0 : cnt_reg + 1'b1;
					wave_reg[gw] <= wave_reg[gw] ^ flip;
				end
			end
		end
	endgenerate
	assign minute_square_wave_o = wave_reg[0];
	assign second_square_wave_o = wave_reg[1];
	assign tenth_second_square_wave_o = wave_reg[2];
	assign twentieth_second_square_wave_o = wave_reg[3];

	// ****************************************
	// Scan and mode flags
	// ****************************************
	logic run_prev_reg;
	logic start_pending_reg;
	logic first_scan_reg;
	logic alt_scan_reg;
	logic stop_reg;
	logic int_en_reg;
	logic run_entry;
	assign run_entry = run_mode_i && !run_prev_reg;
	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			run_prev_reg <= 1'b0;
			start_pending_reg <= 1'b1;
			first_scan_reg <= 1'b0;
			alt_scan_reg <= 1'b0;
		end else begin
			run_prev_reg <= run_mode_i;
			if (scan_start_i) begin
				first_scan_reg <= start_pending_reg || run_entry;
				alt_scan_reg <= !alt_scan_reg;
			end
			if (run_entry || scan_start_i) start_pending_reg <= run_entry && !scan_start_i;
		end
	end
	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			stop_reg <= 1'b0;
			int_en_reg <= 1'b0;
		end else begin
			if (stop_instr_i) stop_reg <= 1'b1;
			else if (run_entry) stop_reg <= 1'b0;
			// Enable wins over a disable in the same cycle
			if (enable_interrupts_instr_i) int_en_reg <= 1'b1;
			else if (disable_interrupts_instr_i || run_entry) int_en_reg <= 1'b0;
		end
	end
	assign first_scan_flag_o = first_scan_reg;
	assign alternating_scan_flag_o = alt_scan_reg;
	assign always_true_flag_o = 1'b1;
	assign always_false_flag_o = 1'b0;
	assign run_mode_flag_o = run_prev_reg;
	assign program_mode_flag_o = !run_prev_reg;
	assign forced_stop_flag_o = stop_reg;
	assign interrupts_enabled_flag_o = int_en_reg;

	// ****************************************
	// Fault flags, sticky until run entry; battery low follows its synchronised pin while config bit 12 is set
	// ****************************************
	logic [15:0] sys_config_reg;
	logic [15:0] error_code_reg;
	logic [7:0] fault_reg;
	logic [7:0] fault_set;
	logic batt_low_reg;
	assign fault_set = {solve_logic_fail_i, syntax_error_i, watchdog_expired_i, fault_instr_i,
		io_config_mismatch_i && sys_config_reg[psf_pkg::CFG_IO_CHECK_BIT],
		io_module_removed_i || io_bus_error_i, parity_error_i, io_comm_loss_i};
	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			fault_reg <= 8'h00;
			batt_low_reg <= 1'b0;
		end else begin
			// New fault wins over the run-entry clear
			fault_reg <= fault_set | (run_entry ? 8'h00 : fault_reg);
			batt_low_reg <= batt_sync_reg[1] && sys_config_reg[psf_pkg::CFG_BATT_MON_BIT];
		end
	end
	assign program_memory_error_flag_o = fault_reg[1];
	assign io_error_flag_o = fault_reg[2];
	assign io_config_error_flag_o = fault_reg[3];
	assign fault_instr_flag_o = fault_reg[4];
	assign watchdog_timeout_flag_o = fault_reg[5];
	assign grammar_error_flag_o = fault_reg[6];
	assign solve_logic_error_flag_o = fault_reg[7];
	assign battery_low_flag_o = batt_low_reg;
	assign critical_error_flag_o = |{fault_reg[0], fault_reg[1], fault_reg[5]};
	assign warning_flag_o = batt_low_reg;

	// ****************************************
	// Accumulator flags
	// ****************************************
	logic [2:0] cmp_reg;
	logic [3:0] carry_reg;
	logic zero_reg, load_zero_reg, sign_reg, ovf_reg;
	logic [2:0] math_err_reg;
	logic acc_is_zero;
	logic is_add;
	logic is_sub;
	logic ovf_now;
	assign acc_is_zero = (acc_i == 32'h0000_0000);
	assign is_add = add16_i || add32_i;
	assign is_sub = sub16_i || sub32_i;
	assign ovf_now = is_add ? (prev_acc_i[31] == operand_i[31]) && (acc_i[31] != prev_acc_i[31])
		: (prev_acc_i[31] != operand_i[31]) && (acc_i[31] != prev_acc_i[31]);
	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			cmp_reg <= 3'h0;
			carry_reg <= 4'h0;
			{zero_reg, load_zero_reg, sign_reg, ovf_reg} <= 4'h0;
		end else begin
			if (compare_i) cmp_reg <= {acc_i > operand_i, acc_i == operand_i,
				acc_i < operand_i};
			if (instr_done_i) begin
				zero_reg <= acc_is_zero;
				sign_reg <= acc_i[31];
			end
			if (instr_done_i && load_instr_i) load_zero_reg <= acc_is_zero;
			if (is_add || is_sub) begin
				carry_reg <= {add32_i & carry_out_i, add16_i & carry_out_i,
					sub32_i & carry_out_i, sub16_i & carry_out_i};
				ovf_reg <= ovf_now;
			end
		end
	end
	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) math_err_reg <= 3'h0;
		else math_err_reg <= {bcd_error_i, invalid_octal_i, underflow_i}
			| (run_entry ? 3'h0 : math_err_reg);
	end
	assign less_than_flag_o = cmp_reg[0];
	assign equal_flag_o = cmp_reg[1];
	assign greater_than_flag_o = cmp_reg[2];
	assign half_borrow_flag_o = carry_reg[0];
	assign full_borrow_flag_o = carry_reg[1];
	assign half_carry_flag_o = carry_reg[2];
	assign full_carry_flag_o = carry_reg[3];
	assign zero_result_flag_o = zero_reg;
	assign load_zero_flag_o = load_zero_reg;
	assign sign_flag_o = sign_reg;
	assign overflow_flag_o = ovf_reg;
	assign underflow_flag_o = math_err_reg[0];
	assign invalid_octal_flag_o = math_err_reg[1];
	assign data_error_flag_o = math_err_reg[2];

	// ****************************************
	// Counter module flags
	// ****************************************
	logic [CNT_W-1:0] preset_mem [psf_pkg::NUM_PRESETS];
	logic [psf_pkg::NUM_PRESETS-1:0] equal_reg;
	logic mirror_reg;
	logic preset_hit;
	logic [4:0] preset_idx;
	assign preset_hit = reg_addr_i[7] && (reg_addr_i[6:2] < 5'(psf_pkg::NUM_PRESETS))
		&& (reg_addr_i[1:0] == 2'h0);
	assign preset_idx = reg_addr_i[6:2];
	genvar gp;
	generate
		for (gp = 0; gp < psf_pkg::NUM_PRESETS; gp++) begin : g_preset
			always_ff @(posedge core_clk_i or negedge rst_n_i) begin
				if (!rst_n_i) begin
					preset_mem[gp] <= '0;
					equal_reg[gp] <= 1'b0;
				end else begin
					if (reg_wr_i && preset_hit && preset_idx == 5'(gp))
						preset_mem[gp] <= reg_wdata_i[CNT_W-1:0];
					equal_reg[gp] <= (counter_value_i == preset_mem[gp]);
				end
			end
		end
	endgenerate
	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) mirror_reg <= 1'b0;
		else mirror_reg <= cim_sync_reg[1];
	end
	assign counter_input_mirror_flag_o = mirror_reg;
	assign preset_equal_flags_o = equal_reg;

	// ****************************************
	// Register port
	// ****************************************
	logic [31:0] flag_word;
	logic [31:0] rdata_next;
	logic [31:0] preset_rd;
	assign flag_word = {fault_reg, batt_low_reg, math_err_reg, ovf_reg, sign_reg,
		load_zero_reg, zero_reg, carry_reg, cmp_reg, int_en_reg, stop_reg, run_prev_reg,
		wave_reg, alt_scan_reg, first_scan_reg};
	assign preset_rd = preset_hit ? 32'(preset_mem[preset_idx]) : 32'h0000_0000;
	assign rdata_next = is_reg(reg_addr_i, psf_pkg::SYS_CONFIG_OFS) ? {16'h0000, sys_config_reg}
		: is_reg(reg_addr_i, psf_pkg::ERROR_CODE_OFS) ? {16'h0000, error_code_reg}
		: is_reg(reg_addr_i, psf_pkg::FLAG_STATUS_OFS) ? flag_word
		: is_reg(reg_addr_i, psf_pkg::PRESET_EQUAL_OFS) ? 32'(equal_reg)
		: preset_rd;
	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			sys_config_reg <= psf_pkg::SYS_CONFIG_RST;
			error_code_reg <= psf_pkg::ERROR_CODE_RST;
			reg_rdata_o <= 32'h0000_0000;
		end else begin
			if (reg_wr_i && is_reg(reg_addr_i, psf_pkg::SYS_CONFIG_OFS))
				sys_config_reg <= reg_wdata_i[15:0];
			if (syntax_error_i) error_code_reg <= syntax_code_i;
			reg_rdata_o <= reg_rd_i ? rdata_next : 32'h0000_0000;
		end
	end

	// ****************************************
	// Assertions
	// ****************************************
	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (!rst_n_i);

	a_first_scan_once: assert property (scan_start_i && !start_pending_reg && !run_entry
		|=> !first_scan_flag_o) else $error("first scan flag held past first scan");
	a_alt_scan_toggle: assert property (scan_start_i |=>
		alternating_scan_flag_o != $past(alternating_scan_flag_o))
		else $error("alternating flag did not toggle");
	a_tick_period: assert property (tick |=> !tick [*2])
		else $error("tick came too soon");
	a_wave_steady: assert property (!tick |=> $stable(wave_reg))
		else $error("square wave changed without a tick");
	a_mode_exclusive: assert property (run_mode_flag_o != program_mode_flag_o)
		else $error("run and program flags agree");
	a_stop_sets: assert property (stop_instr_i |=> forced_stop_flag_o)
		else $error("forced stop flag not set");
	a_int_enable: assert property (enable_interrupts_instr_i |=> interrupts_enabled_flag_o)
		else $error("interrupts enabled flag not set");
	a_critical_sets: assert property (io_comm_loss_i |=> critical_error_flag_o)
		else $error("critical flag missed comm loss");
	a_batt_gated: assert property (!sys_config_reg[psf_pkg::CFG_BATT_MON_BIT]
		|=> !battery_low_flag_o) else $error("battery low while monitor off");
	a_io_error: assert property ((io_module_removed_i || io_bus_error_i) |=> io_error_flag_o)
		else $error("io error flag not set");
	a_cfg_gated: assert property (io_config_mismatch_i
		&& sys_config_reg[psf_pkg::CFG_IO_CHECK_BIT] |=> io_config_error_flag_o)
		else $error("io config error missed");
	a_wdog_flag: assert property (watchdog_expired_i |=> watchdog_timeout_flag_o)
		else $error("watchdog flag not set");
	a_syntax_code: assert property (syntax_error_i |=> grammar_error_flag_o
		&& error_code_reg == $past(syntax_code_i)) else $error("syntax code not stored");
	a_cmp_onehot: assert property (compare_i |=> $onehot({less_than_flag_o, equal_flag_o,
		greater_than_flag_o})) else $error("compare flags not one-hot");
	a_load_zero: assert property (instr_done_i && load_instr_i && acc_is_zero
		|=> load_zero_flag_o && zero_result_flag_o) else $error("load zero flags missing");
	a_carry16: assert property (add16_i && carry_out_i |=> half_carry_flag_o
		&& !full_carry_flag_o) else $error("half carry wrong");
	a_sign_flag: assert property (instr_done_i |=> sign_flag_o == $past(acc_i[31]))
		else $error("sign flag wrong");
	a_bcd_error: assert property (bcd_error_i |=> data_error_flag_o)
		else $error("data error flag not set");
	a_mirror_lag: assert property (cim_sync_reg[1] |=> counter_input_mirror_flag_o)
		else $error("counter input mirror lags");
	a_equal_first: assert property ((counter_value_i == preset_mem[0])
		|=> preset_equal_flags_o[0]) else $error("preset equal flag missed");

	c_first_scan: cover property (run_entry ##[1:20] first_scan_flag_o);
	c_wave_flip: cover property (tick ##1 $rose(twentieth_second_square_wave_o));
	c_compare_less: cover property (compare_i ##1 less_than_flag_o);
	c_fault_clear: cover property (fault_instr_flag_o ##1 run_entry ##1 !fault_instr_flag_o);
endmodule

// ### dv/plc_status_flag_unit_tb.sv
`timescale 1ns/1ns
module plc_status_flag_unit_tb;
	// ****************************************
	// Stimulus and observed signals
	// ****************************************
	logic clk, rst_n, wr, rd, scan, run, bat, cin, cy;
	logic [7:0] addr;
	logic [31:0] wd, rdata, acc, prev, opd, rv;
	logic [14:0] ev;
	logic [6:0] op;
	logic [15:0] cval, scode;
	logic [12:0] fl;
	logic [10:0] af;
	logic [5:0] wv;
	logic t1, t0, runf, progf, warn, batf, mir;
	logic [23:0] peq;
	int n_errors = 0;
	int check_count = 0;

	// Short tick keeps the wave run within budget
	psf_status_flag_unit #(.TICK_CYCLES(10), .CNT_W(16)) i_psf_status_flag_unit (
		.core_clk_i(clk), .rst_n_i(rst_n), .reg_addr_i(addr), .reg_wdata_i(wd),
		.reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata), .scan_start_i(scan),
		.run_mode_i(run), .stop_instr_i(ev[0]), .enable_interrupts_instr_i(ev[1]),
		.disable_interrupts_instr_i(ev[2]), .io_comm_loss_i(ev[3]), .battery_low_pin_i(bat),
		.parity_error_i(ev[4]), .io_module_removed_i(ev[5]), .io_bus_error_i(ev[6]),
		.io_config_mismatch_i(ev[7]), .fault_instr_i(ev[8]), .watchdog_expired_i(ev[9]),
		.solve_logic_fail_i(ev[10]), .syntax_error_i(ev[11]), .syntax_code_i(scode),
		.instr_done_i(op[0]), .load_instr_i(op[1]), .compare_i(op[2]), .add16_i(op[3]),
		.add32_i(op[4]), .sub16_i(op[5]), .sub32_i(op[6]), .carry_out_i(cy), .acc_i(acc),
		.prev_acc_i(prev), .operand_i(opd), .underflow_i(ev[12]), .invalid_octal_i(ev[13]),
		.bcd_error_i(ev[14]), .counter_module_input_zero_i(cin), .counter_value_i(cval),
		.first_scan_flag_o(wv[0]), .always_true_flag_o(t1), .always_false_flag_o(t0),
		.minute_square_wave_o(wv[2]), .second_square_wave_o(wv[3]),
		.tenth_second_square_wave_o(wv[4]), .twentieth_second_square_wave_o(wv[5]),
		.alternating_scan_flag_o(wv[1]), .run_mode_flag_o(runf), .program_mode_flag_o(progf),
		.forced_stop_flag_o(fl[0]), .interrupts_enabled_flag_o(fl[1]),
		.critical_error_flag_o(fl[2]), .warning_flag_o(warn), .battery_low_flag_o(batf),
		.program_memory_error_flag_o(fl[3]), .io_error_flag_o(fl[4]),
		.io_config_error_flag_o(fl[5]), .fault_instr_flag_o(fl[6]),
		.watchdog_timeout_flag_o(fl[7]), .grammar_error_flag_o(fl[9]),
		.solve_logic_error_flag_o(fl[8]), .less_than_flag_o(af[0]), .equal_flag_o(af[1]),
		.greater_than_flag_o(af[2]), .zero_result_flag_o(af[3]), .half_borrow_flag_o(af[4]),
		.full_borrow_flag_o(af[5]), .half_carry_flag_o(af[6]), .full_carry_flag_o(af[7]),
		.sign_flag_o(af[8]), .invalid_octal_flag_o(fl[11]), .overflow_flag_o(af[9]),
		.underflow_flag_o(fl[10]), .data_error_flag_o(fl[12]), .load_zero_flag_o(af[10]),
		.counter_input_mirror_flag_o(mir), .preset_equal_flags_o(peq)
	);

	initial begin
		clk = 1'h0;
		forever #5 clk = ~clk;
	end

	// ****************************************
	// Shared tasks
	// ****************************************
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		check_count++;
		if (g !== e) begin
			n_errors++;
			$display("MISMATCH %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic wreg(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		addr <= a;
		wd <= d;
		wr <= 1'h1;
		@(posedge clk);
		wr <= 1'h0;
	endtask

	// Read data stand only in the cycle after the strobe
	task automatic rreg(input logic [7:0] a, output logic [31:0] d);
		@(posedge clk);
		addr <= a;
		rd <= 1'h1;
		@(posedge clk);
		rd <= 1'h0;
		@(negedge clk);
		d = rdata;
	endtask

	task automatic pulse_ev(input int k);
		@(posedge clk);
		ev[k] <= 1'h1;
		@(posedge clk);
		ev[k] <= 1'h0;
		@(negedge clk);
	endtask

	task automatic pulse_scan();
		@(posedge clk);
		scan <= 1'h1;
		@(posedge clk);
		scan <= 1'h0;
		@(negedge clk);
	endtask

	task automatic set_run(input logic v);
		@(posedge clk);
		run <= v;
		repeat (3) @(posedge clk);
		@(negedge clk);
	endtask

	task automatic mop(input logic [6:0] o, input logic [31:0] a, input logic [31:0] p,
			input logic [31:0] d, input logic c, input logic [10:0] m, input logic [10:0] e);
		@(posedge clk);
		op <= o;
		acc <= a;
		prev <= p;
		opd <= d;
		cy <= c;
		@(posedge clk);
		op <= 7'h00;
		@(negedge clk);
		chk("acc flags", {21'h0, e}, {21'h0, af & m});
	endtask

	task automatic do_reset();
		@(posedge clk);
		rst_n <= 1'h0;
		repeat (10) @(posedge clk);
		rst_n <= 1'h1;
		@(negedge clk);
	endtask

	// ****************************************
	// Scenarios
	// ****************************************
	task automatic t_reset();
		chk("always true", 1, t1);
		chk("always false", 0, t0);
		chk("program mode", 1, progf);
		rreg(psf_pkg::SYS_CONFIG_OFS, rv);
		chk("config reset", {16'h0, psf_pkg::SYS_CONFIG_RST}, rv);
		$display("test reset done");
	endtask

	task automatic t_scan();
		logic a0;
		pulse_scan();
		chk("first scan after reset", 1, wv[0]);
		set_run(1'h1);
		chk("run and program", 2'h2, {runf, progf});
		pulse_scan();
		chk("first scan", 1, wv[0]);
		a0 = wv[1];
		pulse_scan();
		chk("second scan", 0, wv[0]);
		chk("alternate", !a0, wv[1]);
		pulse_scan();
		chk("alternate back", a0, wv[1]);
		set_run(1'h0);
		set_run(1'h1);
		pulse_scan();
		chk("first scan rerun", 1, wv[0]);
		$display("test scan done");
	endtask

	task automatic t_math();
		mop(7'h04, 32'h5, 32'h0, 32'h9, 1'h0, 11'h007, 11'h001);
		mop(7'h04, 32'h9, 32'h0, 32'h9, 1'h0, 11'h007, 11'h002);
		mop(7'h04, 32'hFFFFFFFF, 32'h0, 32'h1, 1'h0, 11'h007, 11'h004);
		mop(7'h03, 32'h0, 32'h0, 32'h0, 1'h0, 11'h408, 11'h408);
		mop(7'h11, 32'h80000000, 32'h7FFFFFFF, 32'h1, 1'h0, 11'h3F8, 11'h300);
		mop(7'h09, 32'h1, 32'hFFFF, 32'h2, 1'h1, 11'h0F0, 11'h040);
		mop(7'h21, 32'hFFFF, 32'h1, 32'h2, 1'h1, 11'h0F0, 11'h010);
		mop(7'h41, 32'hFFFFFFFF, 32'h1, 32'h2, 1'h1, 11'h0F0, 11'h020);
		mop(7'h11, 32'h1, 32'hFFFFFFFF, 32'h2, 1'h1, 11'h0F0, 11'h080);
		$display("test math done");
	endtask

	task automatic t_events();
		int ei[12] = '{0, 1, 3, 4, 6, 8, 9, 10, 11, 12, 13, 14};
		int fi[12] = '{0, 1, 2, 3, 4, 6, 7, 8, 9, 10, 11, 12};
		logic [12:0] pf;
		for (int i = 0; i < 12; i++) begin
			pf = fl;
			pulse_ev(ei[i]);
			chk("event flags", {19'h0, pf | (13'h1 << fi[i])}, {19'h0, fl});
		end
		rreg(psf_pkg::ERROR_CODE_OFS, rv);
		chk("error code", 32'h0A5C, rv);
		pulse_ev(2);
		chk("interrupts disabled", 0, fl[1]);
		@(posedge clk);
		scode <= 16'h13C7;
		pulse_ev(11);
		rreg(psf_pkg::ERROR_CODE_OFS, rv);
		chk("error code update", 32'h13C7, rv);
		set_run(1'h0);
		set_run(1'h1);
		chk("flags after run entry", 0, fl);
		pulse_ev(5);
		chk("module removed", 13'h10, fl);
		rreg(psf_pkg::FLAG_STATUS_OFS, rv);
		chk("flag word faults", 8'h04, rv[31:24]);
		chk("flag word run", 1, rv[6]);
		chk("flag word stop int", 0, rv[8:7]);
		$display("test events done");
	endtask

	task automatic t_cfg();
		@(posedge clk);
		bat <= 1'h1;
		cin <= 1'h1;
		pulse_ev(7);
		repeat (4) @(negedge clk);
		chk("battery gated", 2'h0, {batf, warn});
		chk("io config gated", 0, fl[5]);
		chk("input mirror", 1, mir);
		wreg(psf_pkg::SYS_CONFIG_OFS, 32'h1001);
		pulse_ev(7);
		repeat (4) @(negedge clk);
		chk("battery low", 2'h3, {batf, warn});
		chk("io config", 1, fl[5]);
		rreg(psf_pkg::SYS_CONFIG_OFS, rv);
		chk("config readback", 32'h1001, rv);
		rreg(8'h40, rv);
		chk("unmapped read", 0, rv);
		wreg(psf_pkg::PRESET_BASE_OFS + 8'h14, 32'h1234);
		wreg(psf_pkg::PRESET_BASE_OFS + 8'h5C, 32'h0077);
		cval <= 16'h1234;
		repeat (3) @(negedge clk);
		chk("preset equal 5", 24'h000020, peq);
		@(posedge clk);
		cval <= 16'h0077;
		cin <= 1'h0;
		repeat (4) @(negedge clk);
		chk("preset equal 23", 24'h800000, peq);
		chk("input mirror off", 0, mir);
		rreg(psf_pkg::PRESET_EQUAL_OFS, rv);
		chk("equal word", 32'h00800000, rv);
		$display("test config done");
	endtask

	// Fall times are measured from reset release, so tick phase gives some slack
	task automatic t_waves();
		int n, tf, tr, te, ts;
		int tw = psf_pkg::TWENTIETH_HALF_TICKS * 10;
		n = 0;
		tf = 0;
		tr = 0;
		te = 0;
		ts = 0;
		do_reset();
		while (n < 5200) begin
			@(negedge clk);
			n++;
			if (wv[5] === 1'h0 && tf == 0) tf = n;
			if (wv[5] === 1'h1 && tf != 0 && tr == 0) tr = n;
			if (wv[4] === 1'h0 && te == 0) te = n;
			if (wv[3] === 1'h0 && ts == 0) ts = n;
		end
		chk("twentieth fall", 1, tf >= tw - 2 && tf <= tw + 12);
		chk("twentieth low", tw, tr - tf);
		chk("tenth fall", 1, te >= 2 * tw - 2 && te <= 2 * tw + 12);
		chk("second fall", 1, ts >= 20 * tw - 2 && ts <= 20 * tw + 12);
		chk("minute high", 1, wv[2]);
		$display("test waves done");
	endtask

	task automatic summarize();
		$display("checks %0d mismatches %0d", check_count, n_errors);
		if (n_errors == 0 && check_count > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	initial begin
		{rst_n, wr, rd, scan, run, bat, cin, cy} = 8'h00;
		{addr, wd, acc, prev, opd, ev, op, cval} = 0;
		scode = 16'h0A5C;
		do_reset();
		t_reset();
		t_scan();
		t_math();
		t_events();
		t_cfg();
		t_waves();
		summarize();
	end
endmodule
